// ===== hdl/tmr8_pkg.sv
// package: register map, field layout, reset values and mode codes of the 8-bit waveform timer
package tmr8_pkg;
   // register indices on the plain register port
   localparam logic [2:0] TMR8_OFS_CTRL_A = 3'h0;
   localparam logic [2:0] TMR8_OFS_CTRL_B = 3'h1;
   localparam logic [2:0] TMR8_OFS_COUNT = 3'h2;
   localparam logic [2:0] TMR8_OFS_CMP_A = 3'h3;
   localparam logic [2:0] TMR8_OFS_CMP_B = 3'h4;
   localparam logic [2:0] TMR8_OFS_FLAGS = 3'h5;
   localparam logic [2:0] TMR8_OFS_ASYNC = 3'h6;
   // timer_waveform_control_a fields
   localparam int TMR8_POS_OUT_MODE_A = 6;
   localparam int TMR8_POS_OUT_MODE_B = 4;
   localparam int TMR8_POS_WAVE_LOW = 0;
   localparam logic [7:0] TMR8_CTRL_A_RMASK = 8'hF3;
   // timer_waveform_control_b fields
   localparam int TMR8_POS_WAVE_TOP = 3;
   localparam int TMR8_POS_CLK_SEL = 0;
   localparam logic [7:0] TMR8_CTRL_B_RMASK = 8'h0F;
   // flag register bits, write one to clear, then the async select bit
   localparam int TMR8_POS_OVF = 0;
   localparam int TMR8_POS_MATCH_A = 1;
   localparam int TMR8_POS_MATCH_B = 2;
   localparam int TMR8_POS_ASYNC = 0;
   // reset values
   localparam logic [7:0] TMR8_RST_CTRL_A = 8'h00;
   localparam logic [7:0] TMR8_RST_CTRL_B = 8'h00;
   localparam logic [7:0] TMR8_RST_BYTE = 8'h00;
   // count limits
   localparam logic [7:0] TMR8_MAX = 8'hFF;
   localparam logic [7:0] TMR8_BOTTOM = 8'h00;
   // wave mode codes
   localparam logic [2:0] TMR8_WM_NORMAL = 3'h0;
   localparam logic [2:0] TMR8_WM_PC_FF = 3'h1;
   localparam logic [2:0] TMR8_WM_CTC = 3'h2;
   localparam logic [2:0] TMR8_WM_FAST_FF = 3'h3;
   localparam logic [2:0] TMR8_WM_RSV4 = 3'h4;
   localparam logic [2:0] TMR8_WM_PC_CMP = 3'h5;
   localparam logic [2:0] TMR8_WM_RSV6 = 3'h6;
   localparam logic [2:0] TMR8_WM_FAST_CMP = 3'h7;
   // prescaler: low-bit masks for divide by 8, 32, 64, 128, 256, 1024
   localparam int TMR8_PRE_W = 10;
   localparam logic [9:0] TMR8_DIV8_M = 10'h007;
   localparam logic [9:0] TMR8_DIV32_M = 10'h01F;
   localparam logic [9:0] TMR8_DIV64_M = 10'h03F;
   localparam logic [9:0] TMR8_DIV128_M = 10'h07F;
   localparam logic [9:0] TMR8_DIV256_M = 10'h0FF;
   localparam logic [9:0] TMR8_DIV1024_M = 10'h3FF;
   // count direction, one-hot
   typedef enum logic [1:0] {TMR8_UP = 2'b01, TMR8_DOWN = 2'b10} tmr8_dir_t;
endpackage

// ===== hdl/tmr8_prescale.sv
// prescaler: turns the selected clock source into the one-cycle timer tick
module tmr8_prescale
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // source and tick
   tmr8_tick_if.pre tk
);
   typedef struct packed {
      logic [TMR8_PRE_W-1:0] pre;
   } tmr8_pre_st_t;
   tmr8_pre_st_t s_q;
   tmr8_pre_st_t s_d;
   logic [TMR8_PRE_W-1:0] mask;

   ////////////////////////////////////////////////////////////////////////
   // divider select; a free-running divider means the first tick after a
   // select change may come early, as on the documented part
   always_comb begin
      s_d = s_q;
      mask = '0;
      if (tk.src_en && tk.clock_select != 3'h0) s_d.pre = s_q.pre + 10'h001;
      case (tk.clock_select)
         3'h2: mask = TMR8_DIV8_M;
         3'h3: mask = TMR8_DIV32_M;
         3'h4: mask = TMR8_DIV64_M;
         3'h5: mask = TMR8_DIV128_M;
         3'h6: mask = TMR8_DIV256_M;
         3'h7: mask = TMR8_DIV1024_M;
         default: mask = '0;
      endcase
   end
   // code 0 stops the counter, code 1 passes every source cycle
   assign tk.timer_tick = tk.src_en && tk.clock_select != 3'h0 && (s_q.pre & mask) == mask;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_STOPPED_NO_TICK: assert property (tk.clock_select == 3'h0 |-> !tk.timer_tick)
      else $error("tick while counter stopped");
   AST_DIV8_SPACING: assert property (tk.clock_select == 3'h2 && tk.timer_tick ##1
      tk.clock_select == 3'h2 [*7] |-> !tk.timer_tick)
      else $error("divide by 8 ticks too close");
endmodule // tmr8_prescale

// ===== hdl/tmr8_tick_if.sv
// interface: clock source and select into the prescaler, timer tick back out
interface tmr8_tick_if;
   logic src_en;
   logic [2:0] clock_select;
   logic timer_tick;
   modport core (output src_en, output clock_select, input timer_tick);
   modport pre (input src_en, input clock_select, output timer_tick);
endinterface

// ===== hdl/tmr8_timer.sv
// top: 8-bit timer/counter with two compare channels and waveform generation
//
// How it works
// - nonzero output mode connects compare output to pin; PWM value 1 only on A with top bit
// - non-PWM channel A: off, toggle, clear, set
// - non-PWM channel B: off, toggle, clear, set
// - fast PWM A: 2 clear/set-top, 3 inverse
// - PWM A mode 1 toggles only with top bit
// - phase-correct A: clear up, set down; 3 inverse
// - fast PWM B: 1 reserved, 2/3 as A
// - phase-correct B: 1 reserved, 2/3 as A
// - PWM codes 2/3, compare equal top: match ignored, top action kept
// - control A bits 3 and 2 read zero
// - wave mode joins low bits and top bit
// - modes 0 and 2: immediate update, overflow at max
// - PWM ceilings and compare update at top
// - overflow at bottom, max or top; 4,6 reserved
// - clear-on-match: flag A set, counter cleared
// - counter advances only on timer tick
// - async mode counts timer oscillator ticks
// - clock select stops, passes or prescales
// - fast PWM clears after reaching ceiling
module tmr8_timer
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // timer oscillator, one-cycle pulse per oscillator edge
   input wire logic osc_tick,
   // compare outputs and their pin overrides
   output logic compare_out_a,
   output logic compare_out_a_en,
   output logic compare_out_b,
   output logic compare_out_b_en
);
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic wave_mode_top_bit;
      logic [2:0] clock_select;
      logic async_sel;
      logic [7:0] count_value;
      logic [7:0] compare_value_a;
      logic [7:0] compare_value_b;
      logic [7:0] cmp_buf_a;
      logic [7:0] cmp_buf_b;
      logic overflow_flag;
      logic match_flag_a;
      logic match_flag_b;
      logic out_a;
      logic out_b;
      logic match_block;
      tmr8_dir_t dir;
      logic [7:0] rdata;
   } tmr8_state_t;

   tmr8_state_t s_q;
   tmr8_state_t s_d;
   tmr8_tick_if tk ();
   logic [2:0] wave_mode;
   logic [1:0] out_mode_chan_a;
   logic [1:0] out_mode_chan_b;
   logic is_fast;
   logic is_pc;
   logic is_rsv;
   logic is_imm;
   logic [7:0] top;
   logic at_top;
   logic tick;
   logic hit_a;
   logic hit_b;
   logic wrap;
   logic peak;
   logic down;
   logic wr_count;

   ////////////////////////////////////////////////////////////////////////
   // one output channel: how a match, a wrap or the peak moves the level
   function automatic logic tmr8_chan(input logic cur, input logic [1:0] com, input logic tgl_ok,
                                      input logic fast, input logic pc, input logic dn, input logic hit,
                                      input logic wr, input logic pk, input logic ocr_top);
      logic o;
      logic hit_eff;
      o = cur;
      hit_eff = hit && !ocr_top;
      if (!fast && !pc) begin
         if (hit) begin
            case (com)
               2'h1: o = !cur;
               2'h2: o = 1'b0;
               2'h3: o = 1'b1;
               default: o = cur;
            endcase
         end
      end else if (com == 2'h1) begin
         if (tgl_ok && hit) o = !cur;
      end else if (com[1]) begin
         if (fast) begin
            if (hit_eff) o = com[0];
            if (wr) o = !com[0];
         end else begin
            if (hit_eff) o = dn ? !com[0] : com[0];
            if (pk && ocr_top) o = com[0];
         end
      end
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // mode decode; modes 4 and 6 are reserved and simply hold the counter
   assign out_mode_chan_a = s_q.ctrl_a[TMR8_POS_OUT_MODE_A +: 2];
   assign out_mode_chan_b = s_q.ctrl_a[TMR8_POS_OUT_MODE_B +: 2];
   assign wave_mode = {s_q.wave_mode_top_bit, s_q.ctrl_a[TMR8_POS_WAVE_LOW +: 2]};
   assign is_fast = wave_mode == TMR8_WM_FAST_FF || wave_mode == TMR8_WM_FAST_CMP;
   assign is_pc = wave_mode == TMR8_WM_PC_FF || wave_mode == TMR8_WM_PC_CMP;
   assign is_rsv = wave_mode == TMR8_WM_RSV4 || wave_mode == TMR8_WM_RSV6;
   assign is_imm = wave_mode == TMR8_WM_NORMAL || wave_mode == TMR8_WM_CTC;
   // ceiling: compare A in modes 2, 5 and 7, else the maximum
   assign top = (wave_mode == TMR8_WM_CTC || wave_mode == TMR8_WM_PC_CMP || wave_mode == TMR8_WM_FAST_CMP)
                ? s_q.compare_value_a : TMR8_MAX;
   assign at_top = s_q.count_value == top;
   assign down = is_pc && s_q.dir == TMR8_DOWN;
   assign wr_count = reg_wr && reg_addr == TMR8_OFS_COUNT;

   ////////////////////////////////////////////////////////////////////////
   // tick source: every I/O clock in sync mode, the oscillator pulse in async mode
   assign tk.src_en = s_q.async_sel ? osc_tick : 1'b1;
   assign tk.clock_select = s_q.clock_select;
   assign tick = tk.timer_tick && !is_rsv;

   tmr8_prescale u_pre (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tk(tk.pre)
   );

   // a count write masks the match of the following tick
   assign hit_a = tick && !s_q.match_block && s_q.count_value == s_q.compare_value_a;
   assign hit_b = tick && !s_q.match_block && s_q.count_value == s_q.compare_value_b;
   assign wrap = tick && is_fast && at_top;
   assign peak = tick && is_pc && !down && at_top;

   ////////////////////////////////////////////////////////////////////////
   // next state: counting, flags, waveform, then register writes and reads
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      // overflow clear goes in before counting, so an overflow in the same cycle still sets it
      if (reg_wr && reg_addr == TMR8_OFS_FLAGS && reg_wdata[TMR8_POS_OVF]) s_d.overflow_flag = 1'b0;
      if (tick) begin
         s_d.match_block = 1'b0;
         if (is_pc) begin
            if (!down && at_top) begin
               s_d.dir = TMR8_DOWN;
               s_d.count_value = s_q.count_value - 8'h01;
            end else if (down && s_q.count_value == TMR8_BOTTOM) begin
               s_d.dir = TMR8_UP;
               s_d.count_value = s_q.count_value + 8'h01;
               s_d.overflow_flag = 1'b1;
            end else if (down) begin
               s_d.count_value = s_q.count_value - 8'h01;
            end else begin
               s_d.count_value = s_q.count_value + 8'h01;
            end
         end else begin
            s_d.dir = TMR8_UP;
            if ((is_fast || wave_mode == TMR8_WM_CTC) && at_top) s_d.count_value = TMR8_BOTTOM;
            else s_d.count_value = s_q.count_value + 8'h01;
            if (wave_mode == TMR8_WM_FAST_CMP) begin
               if (at_top) s_d.overflow_flag = 1'b1;
            end else if (s_q.count_value == TMR8_MAX) begin
               s_d.overflow_flag = 1'b1;
            end
         end
         if (hit_a) s_d.match_flag_a = 1'b1;
         if (hit_b) s_d.match_flag_b = 1'b1;
         // buffered compare values load at the ceiling in PWM modes
         if ((is_fast || is_pc) && at_top && !down) begin
            s_d.compare_value_a = s_q.cmp_buf_a;
            s_d.compare_value_b = s_q.cmp_buf_b;
         end
      end
      s_d.out_a = tmr8_chan(s_q.out_a, out_mode_chan_a, s_q.wave_mode_top_bit, is_fast, is_pc, down,
                            hit_a, wrap, peak, s_q.compare_value_a == top);
      s_d.out_b = tmr8_chan(s_q.out_b, out_mode_chan_b, 1'b0, is_fast, is_pc, down,
                            hit_b, wrap, peak, s_q.compare_value_b == top);
      // register writes; a count write overrides the tick
      if (reg_wr) begin
         case (reg_addr)
            TMR8_OFS_CTRL_A: s_d.ctrl_a = reg_wdata & TMR8_CTRL_A_RMASK;
            TMR8_OFS_CTRL_B: begin
               s_d.wave_mode_top_bit = reg_wdata[TMR8_POS_WAVE_TOP];
               s_d.clock_select = reg_wdata[TMR8_POS_CLK_SEL +: 3];
            end
            TMR8_OFS_COUNT: begin
               s_d.count_value = reg_wdata;
               s_d.match_block = 1'b1;
            end
            TMR8_OFS_CMP_A: s_d.cmp_buf_a = reg_wdata;
            TMR8_OFS_CMP_B: s_d.cmp_buf_b = reg_wdata;
            TMR8_OFS_FLAGS: begin
               // a same-cycle hardware set wins: the clear is skipped on a match hit
               if (reg_wdata[TMR8_POS_MATCH_A] && !hit_a) s_d.match_flag_a = 1'b0;
               if (reg_wdata[TMR8_POS_MATCH_B] && !hit_b) s_d.match_flag_b = 1'b0;
            end
            TMR8_OFS_ASYNC: s_d.async_sel = reg_wdata[TMR8_POS_ASYNC];
            default: s_d.rdata = 8'h00;
         endcase
      end
      // immediate modes take the written compare value at once
      if (is_imm || is_rsv) begin
         s_d.compare_value_a = s_d.cmp_buf_a;
         s_d.compare_value_b = s_d.cmp_buf_b;
      end
      // read data appear in the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            TMR8_OFS_CTRL_A: s_d.rdata = s_q.ctrl_a & TMR8_CTRL_A_RMASK;
            TMR8_OFS_CTRL_B: s_d.rdata = {4'h0, s_q.wave_mode_top_bit, s_q.clock_select};
            TMR8_OFS_COUNT: s_d.rdata = s_q.count_value;
            TMR8_OFS_CMP_A: s_d.rdata = s_q.cmp_buf_a;
            TMR8_OFS_CMP_B: s_d.rdata = s_q.cmp_buf_b;
            TMR8_OFS_FLAGS: s_d.rdata = {5'h00, s_q.match_flag_b, s_q.match_flag_a, s_q.overflow_flag};
            TMR8_OFS_ASYNC: s_d.rdata = {7'h00, s_q.async_sel};
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; everything but the direction (up) resets to zero, outputs disconnected
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl_a <= TMR8_RST_CTRL_A;
         s_q.dir <= TMR8_UP;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin override: any nonzero mode connects, except PWM value 1 on B, or on A without the top bit
   always_comb begin
      compare_out_a_en = out_mode_chan_a != 2'h0;
      compare_out_b_en = out_mode_chan_b != 2'h0;
      if ((is_fast || is_pc) && out_mode_chan_a == 2'h1 && !s_q.wave_mode_top_bit) compare_out_a_en = 1'b0;
      if ((is_fast || is_pc) && out_mode_chan_b == 2'h1) compare_out_b_en = 1'b0;
   end
   // the pin driver itself still needs its direction bit set elsewhere
   assign compare_out_a = s_q.out_a;
   assign compare_out_b = s_q.out_b;
   assign reg_rdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_CTRL_A_RSV_ZERO: assert property (reg_rd && reg_addr == TMR8_OFS_CTRL_A |=> reg_rdata[3:2] == 2'h0)
      else $error("reserved control bits read nonzero");
   AST_PIN_CONNECT: assert property (is_imm && out_mode_chan_a != 2'h0 |-> compare_out_a_en)
      else $error("channel A not connected");
   AST_CTC_CLEAR: assert property (wave_mode == TMR8_WM_CTC && hit_a && at_top && !wr_count |=>
      s_q.count_value == 8'h00 && s_q.match_flag_a)
      else $error("clear-on-match did not clear and flag");
   AST_NO_TICK_HOLD: assert property (!tick && !wr_count |=> $stable(s_q.count_value))
      else $error("counter moved without tick");
   AST_FAST_WRAP: assert property (wrap && !wr_count |=> s_q.count_value == 8'h00)
      else $error("fast PWM did not wrap");
   AST_PC_OVF: assert property (tick && down && s_q.count_value == 8'h00 |=> s_q.overflow_flag)
      else $error("phase-correct overflow missed at bottom");
   AST_NORMAL_TOGGLE: assert property (is_imm && out_mode_chan_a == 2'h1 && hit_a |=>
      compare_out_a != $past(compare_out_a))
      else $error("toggle on match missing");
   AST_FAST_SET_TOP: assert property (wrap && out_mode_chan_a == 2'h2 |=> compare_out_a)
      else $error("non-inverted fast PWM not set at top");
   AST_B_CLEAR: assert property (is_imm && out_mode_chan_b == 2'h2 && hit_b |=> !compare_out_b)
      else $error("channel B not cleared on match");
   AST_READ_LATENCY: assert property (reg_rd && reg_addr == TMR8_OFS_COUNT ##1 !reg_rd |=>
      reg_rdata == 8'h00)
      else $error("read data stood more than one cycle");
   // set must win over a software clear in the same cycle
   AST_MAX_OVF: assert property (tick && s_q.count_value == TMR8_MAX &&
      (is_imm || wave_mode == TMR8_WM_FAST_FF) |=> s_q.overflow_flag)
      else $error("overflow missed at maximum");
   AST_TOP7_OVF: assert property (tick && wave_mode == TMR8_WM_FAST_CMP && at_top |=> s_q.overflow_flag)
      else $error("overflow missed at ceiling");
   AST_MATCH_A_SET: assert property (hit_a |=> s_q.match_flag_a)
      else $error("match flag A lost");
   AST_RSV_HOLD: assert property (is_rsv && !wr_count |=> $stable(s_q.count_value))
      else $error("counter moved in reserved mode");
   // buffered compare values: at once in immediate modes, at the ceiling in fast PWM
   AST_IMM_UPDATE: assert property (reg_wr && reg_addr == TMR8_OFS_CMP_A && is_imm |=>
      s_q.compare_value_a == $past(reg_wdata))
      else $error("immediate compare update missed");
   AST_BUF_AT_TOP: assert property (tick && is_fast && at_top |=>
      s_q.compare_value_a == $past(s_q.cmp_buf_a))
      else $error("compare buffer not loaded at ceiling");

   COV_CTC_MATCH: cover property (wave_mode == TMR8_WM_CTC && hit_a);
   COV_FAST_WRAP: cover property (wrap ##[1:300] wrap);
   COV_PC_PEAK: cover property (peak ##[1:600] (tick && down && s_q.count_value == 8'h00));
   COV_RSV_TICK: cover property (is_rsv && tk.timer_tick);
endmodule // tmr8_timer

// ===== verification/tmr8_pin_model.sv
// partner model: port pin fed by a compare output, with direction bit and pull-up
module tmr8_pin_model (
   // waveform side
   input wire logic drive_lvl,
   input wire logic drive_en,
   // port side
   input wire logic dir_out,
   input wire logic port_lvl,
   // pad
   output logic pin
);
   timeunit 1ns;
   timeprecision 100ps;

   ////////////////////////////////////////////////////////////////////////////////
   // the output driver is off unless software picked output; the pad then floats to the pull-up
   always_comb begin
      if (!dir_out) begin
         pin = 1'b1;
      end else if (drive_en) begin
         pin = drive_lvl; // waveform overrides the port latch
      end else begin
         pin = port_lvl;
      end
   end
endmodule // tmr8_pin_model

// ===== verification/tmr8_timer_test.sv
// testbench: register port, waveform modes, count rates and pin behaviour of the 8-bit timer
module tmr8_timer_test;
   import tmr8_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} tmr8_row_t;

   logic ref_clk, rst_n, reg_wr, reg_rd, dir_a, dir_b;
   logic osc_tick = 1'b0;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d, c0, c1;
   logic compare_out_a, compare_out_a_en, compare_out_b, compare_out_b_en, pin_a, pin_b;
   logic [1:0] osc_phase = 2'h0;
   int fail_count, comparisons, g, hi_a, hi_b, inv_err;
   int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   // ordinary register cases: write, read back, expected value
   tmr8_row_t rows [8] = '{'{TMR8_OFS_CTRL_A, 8'hFF, 8'hF3}, '{TMR8_OFS_CTRL_A, 8'h0C, 8'h00},
      '{TMR8_OFS_CTRL_B, 8'hF7, 8'h07}, '{TMR8_OFS_CTRL_B, 8'h00, 8'h00}, '{TMR8_OFS_COUNT, 8'h7F, 8'h7F},
      '{TMR8_OFS_CMP_A, 8'hA5, 8'hA5}, '{TMR8_OFS_CMP_B, 8'h3C, 8'h3C}, '{3'h7, 8'hFF, 8'h00}};

   tmr8_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
      .compare_out_a(compare_out_a), .compare_out_a_en(compare_out_a_en),
      .compare_out_b(compare_out_b), .compare_out_b_en(compare_out_b_en));
   tmr8_pin_model pa (.drive_lvl(compare_out_a), .drive_en(compare_out_a_en), .dir_out(dir_a),
      .port_lvl(1'b0), .pin(pin_a));
   tmr8_pin_model pb (.drive_lvl(compare_out_b), .drive_en(compare_out_b_en), .dir_out(dir_b),
      .port_lvl(1'b0), .pin(pin_b));

   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // oscillator pulse every fourth cycle, unrelated to any register access
   always @(posedge ref_clk) begin
      osc_phase <= osc_phase + 2'h1;
      osc_tick <= (osc_phase == 2'h3);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one-cycle strobes; the idle edge between calls keeps each strobe a single pulse
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // counts advanced over w cycles between the two sampling edges of the reads
   task automatic rate(input logic [2:0] cs, input int w, output logic [7:0] diff);
      wr(TMR8_OFS_CTRL_B, {5'h00, cs});
      rd(TMR8_OFS_COUNT, c0);
      repeat (w - 2) @(posedge ref_clk);
      rd(TMR8_OFS_COUNT, c1);
      diff = c1 - c0;
   endtask

   // cycles between two level changes of one output, bounded so a dead output cannot hang
   task automatic edge_gap(input bit sel, output int gap);
      logic last;
      int n;
      gap = 0;
      @(posedge ref_clk);
      #1 last = sel ? compare_out_b : compare_out_a;
      // look after each edge has settled, or every gap comes out one short
      for (n = 0; n < 2000 && (sel ? compare_out_b : compare_out_a) === last; n++) begin
         @(posedge ref_clk);
         #1;
      end
      #1 last = sel ? compare_out_b : compare_out_a;
      for (n = 0; n < 2000; n++) begin
         @(posedge ref_clk);
         #1 gap++;
         if ((sel ? compare_out_b : compare_out_a) !== last) break;
      end
   endtask

   // high time of both outputs and cycles where they are not each other's inverse
   task automatic watch(input int n);
      hi_a = 0;
      hi_b = 0;
      inv_err = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1 hi_a += (compare_out_a === 1'b1);
         hi_b += (compare_out_b === 1'b1);
         inv_err += (compare_out_a === compare_out_b);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog sized well above the whole sequence
   initial begin
      repeat (80000) @(posedge ref_clk);
      fail_count++;
      close_out;
   end

   initial begin
      {rst_n, reg_wr, reg_rd, dir_a, dir_b} = '0;
      {reg_addr, reg_wdata} = '0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(i[2:0], d);
         chk(d, 8'h00);
      end
      chk({compare_out_a_en, compare_out_b_en}, 2'b00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         chk(d, rows[i].r);
      end
      // clear-on-match, toggle on both channels
      wr(TMR8_OFS_CMP_A, 8'h03);
      wr(TMR8_OFS_CMP_B, 8'h01);
      wr(TMR8_OFS_CTRL_A, 8'h52);
      wr(TMR8_OFS_CTRL_B, 8'h01);
      chk({compare_out_a_en, compare_out_b_en}, 2'b11);
      edge_gap(0, g);
      chk(g, 4);
      edge_gap(1, g);
      chk(g, 4);
      wr(TMR8_OFS_FLAGS, 8'h07);
      repeat (300) @(posedge ref_clk);
      rd(TMR8_OFS_FLAGS, d);
      chk(d & 8'h03, 8'h02);
      // clear and set codes on both channels, then the pin seen through the port
      wr(TMR8_OFS_CTRL_A, 8'hB2);
      repeat (10) @(posedge ref_clk);
      chk({compare_out_a, compare_out_b}, 2'b01);
      wr(TMR8_OFS_CTRL_A, 8'hE2);
      repeat (10) @(posedge ref_clk);
      chk({compare_out_a, compare_out_b}, 2'b10);
      #1 chk(pin_b, 1'b1);
      dir_b <= 1'b1;
      dir_a <= 1'b1;
      #1 chk({pin_a, pin_b}, 2'b10);
      // fast pwm with the full-range ceiling
      wr(TMR8_OFS_CMP_A, 8'h80);
      wr(TMR8_OFS_CMP_B, 8'h80);
      wr(TMR8_OFS_CTRL_A, 8'hB3);
      repeat (300) @(posedge ref_clk);
      watch(512);
      chk(hi_a, 258);
      chk(inv_err, 0);
      rd(TMR8_OFS_FLAGS, d);
      chk(d[TMR8_POS_OVF], 1'b1);
      wr(TMR8_OFS_CTRL_A, 8'h53);
      #1 chk({compare_out_a_en, compare_out_b_en}, 2'b00);
      // fast pwm with compare a as ceiling; new compare values wait for the top
      wr(TMR8_OFS_CMP_A, 8'h05);
      wr(TMR8_OFS_CMP_B, 8'h02);
      repeat (300) @(posedge ref_clk);
      wr(TMR8_OFS_CTRL_A, 8'h63);
      wr(TMR8_OFS_CTRL_B, 8'h09);
      repeat (300) @(posedge ref_clk);
      chk(compare_out_a_en, 1'b1);
      watch(60);
      chk(hi_b, 30);
      edge_gap(0, g);
      chk(g, 6);
      wr(TMR8_OFS_CTRL_A, 8'hA3);
      repeat (20) @(posedge ref_clk);
      watch(60);
      chk(hi_a, 60);
      // phase correct, inverted a against plain b on one compare value
      wr(TMR8_OFS_CTRL_B, 8'h01);
      wr(TMR8_OFS_CTRL_A, 8'hE1);
      wr(TMR8_OFS_CMP_A, 8'h40);
      wr(TMR8_OFS_CMP_B, 8'h40);
      repeat (1100) @(posedge ref_clk);
      watch(510);
      chk(inv_err, 0);
      chk(hi_b, 128);
      // count rates: every clock select code in normal mode, then the oscillator source
      wr(TMR8_OFS_CTRL_A, 8'h00);
      for (int cs = 1; cs < 8; cs++) begin
         rate(cs[2:0], divs[cs] * 10, d);
         chk(d, 8'h0A);
      end
      rate(3'h0, 40, d);
      chk(d, 8'h00);
      // reserved wave mode 4 with a running clock holds the counter
      wr(TMR8_OFS_CTRL_B, 8'h09);
      rd(TMR8_OFS_COUNT, c0);
      repeat (20) @(posedge ref_clk);
      rd(TMR8_OFS_COUNT, c1);
      chk(c1 - c0, 8'h00);
      wr(TMR8_OFS_ASYNC, 8'h01);
      rate(3'h1, 40, d);
      chk(d, 8'h0A);
      wr(TMR8_OFS_ASYNC, 8'h00);
      // reset in mid-run: control A and counter back to zero, outputs disconnected
      wr(TMR8_OFS_CTRL_A, 8'hB3);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk({compare_out_a_en, compare_out_b_en}, 2'b00);
      rd(TMR8_OFS_CTRL_A, d);
      chk(d, 8'h00);
      rd(TMR8_OFS_COUNT, d);
      chk(d, 8'h00);
      close_out;
   end
endmodule // tmr8_timer_test
